/* core/icwtb_pkg.sv */
// Constants, register map and carrier types of the interrupt controller with time base.
package icwtb_pkg;

	// ************************************************************
	// Register map, byte addresses on the Avalon-MM slave.
	// ************************************************************
	localparam logic [4:0] PRIMARY_OFF  = 5'h00;
	localparam logic [4:0] SHARED_OFF   = 5'h04;
	localparam logic [4:0] CMP_OFF      = 5'h08;
	localparam logic [4:0] PSC_OFF      = 5'h0c;
	localparam logic [4:0] TICK_OFF     = 5'h10;
	localparam logic [4:0] STATUS_OFF   = 5'h14;

	// ************************************************************
	// Field positions.
	// ************************************************************
	localparam int GLOBAL_EN_BIT = 0;
	localparam int TICK_EN_BIT   = 2;
	localparam int TICK_FLAG_BIT = 5;
	localparam int SHARED_EN_BIT = 0;
	localparam int SHARED_FL_BIT = 4;
	localparam int CMP_P_EN_BIT  = 0;
	localparam int CMP_A_EN_BIT  = 1;
	localparam int CMP_P_FL_BIT  = 4;
	localparam int CMP_A_FL_BIT  = 5;
	localparam int TICK_ON_BIT   = 7;
	localparam int STAT_FULL_BIT = 7;

	// ************************************************************
	// Reset values, sizes and vectors.
	// ************************************************************
	localparam logic [7:0]  REG_RESET      = 8'h00;
	localparam int          PC_W           = 12;
	localparam int          STACK_DEPTH    = 4;
	localparam int          SP_W           = 3;
	localparam logic [11:0] SHARED_VEC     = 12'h004;
	localparam logic [11:0] TICK_VEC       = 12'h008;
	localparam logic [3:0]  TICK_MIN_SHIFT = 4'h8;
	localparam logic [1:0]  PSC_DIV4_LAST  = 2'h3;
	localparam logic [1:0]  SRC_SYS        = 2'h0;
	localparam logic [1:0]  SRC_SYS_DIV4   = 2'h1;

	// CPU to controller: boundary, stack operations and next address.
	typedef struct packed {
		logic              boundary;
		logic              call;
		logic              ret;
		logic              return_from_irq;
		logic [PC_W-1:0]   next_pc;
	} icwtb_cpu_req_t;

	// Controller to CPU: program counter load and stack state.
	typedef struct packed {
		logic              pc_load;
		logic [PC_W-1:0]   pc_addr;
		logic              irq_taken;
		logic              stack_full;
	} icwtb_cpu_rsp_t;

endpackage

/* core/icwtb_ctrl.sv */
// Interrupt controller with time base, return stack and Avalon-MM register slave.
//
// What this block does
// - Source event sets its flag regardless of enables
// - Disabled request keeps flag, no vectoring
// - Global enable low suppresses all vectoring
// - Taking interrupt pushes next PC, loads vector
// - Return from interrupt pops saved PC, resumes
// - Servicing clears global enable; flags keep latching
// - Full stack withholds acknowledgement of requests
// - Simultaneous requests resolved by fixed priority
// - Any flag set wakes from sleep or idle
// - Member comparator flag rise sets shared flag
// - Shared service clears shared flag, global enable
// - Shared service leaves member flags untouched
// - Divider overflow sets the tick flag
// - Tick vectors with global, tick enable, stack room
// - Tick service clears tick flag, global enable
// - Source field picks system, quarter, low-speed clock
// - Period is two to eight-plus-field prescaler cycles
// - Tick control bit 7 turns divider on
// - Comparator matches set P and A flags
// - Comparator vectors need global, own, shared enables
// - Unimplemented control bits read as zero
// - Tick flag is primary control bit 5
// - Wake on flag rise regardless of enable
// - Return from interrupt sets global enable; return not
//
// Design decisions made here: the register offsets and the Avalon-MM register port.
module icwtb_ctrl
	import icwtb_pkg::*;
(
	input  wire logic           mclk,
	input  wire logic           rst_n,
	input  wire logic [4:0]     avs_address,
	input  wire logic           avs_read,
	input  wire logic           avs_write,
	input  wire logic [31:0]    avs_writedata,
	input  wire logic [3:0]     avs_byteenable,
	output logic      [31:0]    avs_readdata,
	output logic                avs_waitrequest,
	input  wire icwtb_cpu_req_t cpu_req,
	output icwtb_cpu_rsp_t      cpu_rsp,
	input  wire logic           cmp_p_match,
	input  wire logic           cmp_a_match,
	input  wire logic           low_speed_tick,
	output logic                wake
);

	// ************************************************************
	// Control and status state.
	// ************************************************************
	logic               global_irq_enable;
	logic               tick_irq_enable;
	logic               tick_irq_flag;
	logic               shared_irq_enable;
	logic               shared_irq_flag;
	logic               cmp_p_match_enable;
	logic               cmp_a_match_enable;
	logic               cmp_p_match_flag;
	logic               cmp_a_match_flag;
	logic [1:0]         tick_source_sel;
	logic               tick_divider_on;
	logic [2:0]         tick_period_sel;
	logic               next_global_irq_enable;
	logic               next_tick_irq_flag;
	logic               next_shared_irq_flag;
	logic               next_cmp_p_match_flag;
	logic               next_cmp_a_match_flag;

	// ************************************************************
	// Bus slave: one wait state on every access.
	// ************************************************************
	logic               bus_ack;
	logic               bus_req;
	logic               wr_go;
	logic               wr_primary;
	logic               wr_shared;
	logic               wr_cmp;
	logic               wr_psc;
	logic               wr_tick;
	logic [7:0]         wd;
	logic [7:0]         rd_byte;

	// The request waits one cycle, then completes on the acknowledge edge.
	assign bus_req         = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~bus_ack;
	assign wr_go           = avs_write & bus_ack & avs_byteenable[0];
	assign wd              = avs_writedata[7:0];
	assign wr_primary      = wr_go & (avs_address == PRIMARY_OFF);
	assign wr_shared       = wr_go & (avs_address == SHARED_OFF);
	assign wr_cmp          = wr_go & (avs_address == CMP_OFF);
	assign wr_psc          = wr_go & (avs_address == PSC_OFF);
	assign wr_tick         = wr_go & (avs_address == TICK_OFF);

	// Acknowledge toggles so that back-to-back requests each get a wait state.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= bus_req & ~bus_ack;
		end
	end

	// ************************************************************
	// Return stack.
	// ************************************************************
	logic [PC_W-1:0]    stack_mem [STACK_DEPTH];
	logic [SP_W-1:0]    stack_ptr;
	logic               stack_full;
	logic               stack_empty;
	logic               cpu_busy;
	logic               do_push;
	logic               do_pop;
	logic [PC_W-1:0]    push_data;

	assign stack_full  = (stack_ptr == SP_W'(STACK_DEPTH));
	assign stack_empty = (stack_ptr == '0);
	assign cpu_busy    = cpu_req.call | cpu_req.ret | cpu_req.return_from_irq;

	// ************************************************************
	// Request qualification and priority.
	// ************************************************************
	localparam logic SHARED_FIRST = (SHARED_VEC < TICK_VEC);
	logic               tick_req;
	logic               shared_req;
	logic               take;
	logic               take_tick;
	logic               take_shared;

	// Tick request needs its own flag and enable.
	assign tick_req    = tick_irq_flag & tick_irq_enable;
	// Shared request needs the shared flag, shared enable and an enabled member.
	assign shared_req  = shared_irq_flag & shared_irq_enable &
	                     ((cmp_p_match_flag & cmp_p_match_enable) |
	                      (cmp_a_match_flag & cmp_a_match_enable));
	// Acknowledge only at a quiet instruction boundary with global enable and stack room.
	assign take        = cpu_req.boundary & ~cpu_busy & global_irq_enable & ~stack_full &
	                     (tick_req | shared_req);
	// Exactly one source is taken; the lower vector address wins a tie.
	assign take_tick   = take & tick_req & (~shared_req | ~SHARED_FIRST);
	assign take_shared = take & ~take_tick;

	// Interrupt entries and CPU calls push while the stack has room; returns pop when anything is stacked.
	assign do_push   = take | (cpu_req.call & ~stack_full);
	assign do_pop    = (cpu_req.ret | cpu_req.return_from_irq) & ~stack_empty;
	assign push_data = cpu_req.next_pc;

	// Stack pointer; a push wins over a pop.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stack_ptr <= '0;
		end else if (do_push) begin
			stack_ptr <= stack_ptr + SP_W'(1);
		end else if (do_pop) begin
			stack_ptr <= stack_ptr - SP_W'(1);
		end
	end

	// Only the entry at the pointer is written on a push.
	always_ff @(posedge mclk) begin
		if (do_push) begin
			stack_mem[stack_ptr[SP_W-2:0]] <= push_data;
		end
	end

	// ************************************************************
	// Program counter redirection towards the CPU.
	// ************************************************************
	logic               pc_load;
	logic [PC_W-1:0]    pc_addr;
	logic               irq_taken;

	// A taken interrupt loads its vector; a return loads the popped address.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pc_load   <= 1'b0;
			pc_addr   <= '0;
			irq_taken <= 1'b0;
		end else begin
			pc_load   <= take | do_pop;
			irq_taken <= take;
			if (take) begin
				pc_addr <= take_tick ? TICK_VEC : SHARED_VEC;
			end else if (do_pop) begin
				pc_addr <= stack_mem[(SP_W-1)'(stack_ptr - SP_W'(1))];
			end
		end
	end

	assign cpu_rsp.pc_load    = pc_load;
	assign cpu_rsp.pc_addr    = pc_addr;
	assign cpu_rsp.irq_taken  = irq_taken;
	assign cpu_rsp.stack_full = stack_full;

	// ************************************************************
	// Time base prescaler and divider.
	// ************************************************************
	logic [1:0]         quarter_cnt;
	logic               psc_tick;
	logic [14:0]        tick_cnt;
	logic [14:0]        tick_mask;
	logic               tick_overflow;

	// Free-running divide-by-four of the system clock.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			quarter_cnt <= '0;
		end else begin
			quarter_cnt <= quarter_cnt + 2'h1;
		end
	end

	// Prescaler clock enable from the selected source.
	always_comb begin
		case (tick_source_sel)
			SRC_SYS:      psc_tick = 1'b1;
			SRC_SYS_DIV4: psc_tick = (quarter_cnt == PSC_DIV4_LAST);
			default:      psc_tick = low_speed_tick;
		endcase
	end

	// Overflow when the low eight-plus-field bits are all ones.
	assign tick_mask     = ~(15'h7fff << (TICK_MIN_SHIFT + {1'b0, tick_period_sel}));
	assign tick_overflow = psc_tick & ((tick_cnt & tick_mask) == tick_mask);

	// Divider counts prescaler ticks and sits at zero while switched off.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt <= '0;
		end else if (!tick_divider_on) begin
			tick_cnt <= '0;
		end else if (tick_overflow) begin
			tick_cnt <= '0;
		end else if (psc_tick) begin
			tick_cnt <= tick_cnt + 15'h0001;
		end
	end

	// ************************************************************
	// Flag and global enable update; hardware set beats every clear.
	// ************************************************************
	logic               tick_set;
	logic               member_rise;

	assign tick_set = tick_divider_on & tick_overflow;

	always_comb begin
		next_cmp_p_match_flag = wr_cmp ? wd[CMP_P_FL_BIT] : cmp_p_match_flag;
		next_cmp_a_match_flag = wr_cmp ? wd[CMP_A_FL_BIT] : cmp_a_match_flag;
		// Member flags are never cleared by a service.
		next_cmp_p_match_flag = next_cmp_p_match_flag | cmp_p_match;
		next_cmp_a_match_flag = next_cmp_a_match_flag | cmp_a_match;
		member_rise = (next_cmp_p_match_flag & ~cmp_p_match_flag) |
		              (next_cmp_a_match_flag & ~cmp_a_match_flag);
		next_shared_irq_flag = wr_shared ? wd[SHARED_FL_BIT] : shared_irq_flag;
		next_shared_irq_flag = (next_shared_irq_flag & ~take_shared) | member_rise;
		next_tick_irq_flag   = wr_primary ? wd[TICK_FLAG_BIT] : tick_irq_flag;
		next_tick_irq_flag   = (next_tick_irq_flag & ~take_tick) | tick_set;
		next_global_irq_enable = wr_primary ? wd[GLOBAL_EN_BIT] : global_irq_enable;
		if (cpu_req.return_from_irq) begin
			next_global_irq_enable = 1'b1;
		end
		if (take) begin
			next_global_irq_enable = 1'b0;
		end
	end

	// Flags and global enable.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			global_irq_enable <= 1'b0;
			tick_irq_flag     <= 1'b0;
			shared_irq_flag   <= 1'b0;
			cmp_p_match_flag  <= 1'b0;
			cmp_a_match_flag  <= 1'b0;
		end else begin
			global_irq_enable <= next_global_irq_enable;
			tick_irq_flag     <= next_tick_irq_flag;
			shared_irq_flag   <= next_shared_irq_flag;
			cmp_p_match_flag  <= next_cmp_p_match_flag;
			cmp_a_match_flag  <= next_cmp_a_match_flag;
		end
	end

	// Enables and time base configuration written by software only.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tick_irq_enable    <= REG_RESET[0];
			shared_irq_enable  <= REG_RESET[0];
			cmp_p_match_enable <= REG_RESET[0];
			cmp_a_match_enable <= REG_RESET[0];
			tick_source_sel    <= REG_RESET[1:0];
			tick_divider_on    <= REG_RESET[0];
			tick_period_sel    <= REG_RESET[2:0];
		end else begin
			if (wr_primary) begin
				tick_irq_enable <= wd[TICK_EN_BIT];
			end
			if (wr_shared) begin
				shared_irq_enable <= wd[SHARED_EN_BIT];
			end
			if (wr_cmp) begin
				cmp_p_match_enable <= wd[CMP_P_EN_BIT];
				cmp_a_match_enable <= wd[CMP_A_EN_BIT];
			end
			if (wr_psc) begin
				tick_source_sel <= wd[1:0];
			end
			if (wr_tick) begin
				tick_divider_on <= wd[TICK_ON_BIT];
				tick_period_sel <= wd[2:0];
			end
		end
	end

	// ************************************************************
	// Wake-up on any flag rising, whatever the enables.
	// ************************************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wake <= 1'b0;
		end else begin
			wake <= (next_tick_irq_flag & ~tick_irq_flag) |
			        (next_shared_irq_flag & ~shared_irq_flag) |
			        (next_cmp_p_match_flag & ~cmp_p_match_flag) |
			        (next_cmp_a_match_flag & ~cmp_a_match_flag);
		end
	end

	// ************************************************************
	// Read path; unused bits and unmapped addresses read zero.
	// ************************************************************
	always_comb begin
		rd_byte = 8'h00;
		case (avs_address)
			PRIMARY_OFF: begin
				rd_byte[GLOBAL_EN_BIT] = global_irq_enable;
				rd_byte[TICK_EN_BIT]   = tick_irq_enable;
				rd_byte[TICK_FLAG_BIT] = tick_irq_flag;
			end
			SHARED_OFF: begin
				rd_byte[SHARED_EN_BIT] = shared_irq_enable;
				rd_byte[SHARED_FL_BIT] = shared_irq_flag;
			end
			CMP_OFF: begin
				rd_byte[CMP_P_EN_BIT] = cmp_p_match_enable;
				rd_byte[CMP_A_EN_BIT] = cmp_a_match_enable;
				rd_byte[CMP_P_FL_BIT] = cmp_p_match_flag;
				rd_byte[CMP_A_FL_BIT] = cmp_a_match_flag;
			end
			PSC_OFF: begin
				rd_byte[1:0] = tick_source_sel;
			end
			TICK_OFF: begin
				rd_byte[TICK_ON_BIT] = tick_divider_on;
				rd_byte[2:0]         = tick_period_sel;
			end
			STATUS_OFF: begin
				rd_byte[STAT_FULL_BIT] = stack_full;
				rd_byte[SP_W-1:0]      = stack_ptr;
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// Read data is captured during the wait state and stands at the acknowledge edge.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read & ~bus_ack) begin
			avs_readdata <= {24'h00_0000, rd_byte};
		end
	end

endmodule

/* sim/icwtb_ctrl_properties.sv */
// Port-level assertions for the interrupt controller with time base.
module icwtb_ctrl_properties
	import icwtb_pkg::*;
(
	input wire logic           mclk,
	input wire logic           rst_n,
	input wire logic           avs_read,
	input wire logic           avs_write,
	input wire logic [31:0]    avs_readdata,
	input wire logic           avs_waitrequest,
	input wire icwtb_cpu_req_t cpu_req,
	input wire icwtb_cpu_rsp_t cpu_rsp
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****
	// Checks
	// ****
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic rq;
	// A request is pending on the bus.
	assign rq = avs_read | avs_write;
	a_take_load: assert property (cpu_rsp.irq_taken |-> cpu_rsp.pc_load)
		else $error("entry without load");
	a_vec_legal: assert property (cpu_rsp.irq_taken |->
		cpu_rsp.pc_addr == SHARED_VEC || cpu_rsp.pc_addr == TICK_VEC)
		else $error("entry to an unknown vector");
	a_take_room: assert property (cpu_rsp.irq_taken |->
		!$past(cpu_rsp.stack_full) && $past(cpu_req.boundary))
		else $error("entry with a full stack");
	a_take_quiet: assert property (cpu_rsp.irq_taken |->
		!$past(cpu_req.call | cpu_req.ret | cpu_req.return_from_irq))
		else $error("entry beside a stack operation");
	a_take_once: assert property (cpu_rsp.irq_taken |=> !cpu_rsp.irq_taken)
		else $error("second entry without a return");
	a_full_cause: assert property ($rose(cpu_rsp.stack_full) |->
		$past(cpu_req.call) || cpu_rsp.irq_taken)
		else $error("stack filled without a push");
	a_addr_hold: assert property (!cpu_rsp.pc_load |-> $stable(cpu_rsp.pc_addr))
		else $error("address moved without a load");
	a_wait_one: assert property (rq && avs_waitrequest |=> !avs_waitrequest)
		else $error("more than one wait state");
	a_idle_free: assert property (!rq |-> !avs_waitrequest)
		else $error("wait without a request");
	a_rd_upper: assert property (avs_read && !avs_waitrequest |->
		avs_readdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	c_tick: cover property (cpu_rsp.irq_taken && cpu_rsp.pc_addr == TICK_VEC);
	c_shared: cover property (cpu_rsp.irq_taken && cpu_rsp.pc_addr == SHARED_VEC);
	c_full: cover property (cpu_rsp.stack_full);
endmodule

bind icwtb_ctrl icwtb_ctrl_properties u_props (.mclk(mclk), .rst_n(rst_n),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp));

/* sim/icwtb_partner.sv */
// Behavioural CPU core and comparator event sources beside the controller.
module icwtb_partner
	import icwtb_pkg::*;
(
	input  wire icwtb_cpu_rsp_t cpu_rsp,
	input  wire logic           mclk,
	output icwtb_cpu_req_t      cpu_req,
	output logic                cmp_p_match,
	output logic                cmp_a_match,
	output logic                low_speed_tick
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [PC_W-1:0] pc       = 12'h100;
	logic [PC_W-1:0] saved    = 12'h000;
	logic [4:0]      cmd      = 5'h00;
	logic [4:0]      op       = 5'h00;
	logic [2:0]      ls_cnt   = 3'h0;
	logic [1:0]      dly      = 2'h0;
	logic            auto_ret = 1'b1;
	logic            bnd      = 1'b1;

	// Pulses are call, ret, return_from_irq, match P, match A; the bench may hold the core off a boundary.
	assign cpu_req = {bnd, op[4:2], pc + 12'h001};
	assign cmp_p_match = op[1];
	assign cmp_a_match = op[0];
	assign low_speed_tick = (ls_cnt == 3'h7);

	// Core follows loads, notes the pushed address and returns after a short routine.
	always @(posedge mclk) begin
		pc <= cpu_rsp.pc_load ? cpu_rsp.pc_addr : pc + 12'h001;
		ls_cnt <= ls_cnt + 3'h1;
		if (cpu_rsp.irq_taken)
			saved <= pc;
		dly <= (cpu_rsp.irq_taken && auto_ret) ? 2'h3 : dly - {1'b0, dly != 2'h0};
		op <= (dly == 2'h1) ? 5'h04 : cmd;
	end

	// Issues one set of pulses for a single cycle.
	task automatic send(input logic [4:0] k);
		@(posedge mclk);
		cmd <= k;
		@(posedge mclk);
		cmd <= 5'h00;
	endtask
endmodule

/* sim/icwtb_ctrl_tb.sv */
// Self-checking testbench of the interrupt controller with time base.
module icwtb_ctrl_tb
	import icwtb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic           mclk = 1'b0;
	logic           rst_n = 1'b0;
	logic [4:0]     avs_address;
	logic           avs_read;
	logic           avs_write;
	logic [31:0]    avs_writedata;
	logic [3:0]     avs_byteenable;
	logic [31:0]    avs_readdata;
	logic           avs_waitrequest;
	icwtb_cpu_req_t cpu_req;
	icwtb_cpu_rsp_t cpu_rsp;
	logic           cmp_p, cmp_a, ls_tick, wake;
	int             n_mismatch = 0;
	int             n_compared = 0;
	int             n_wake = 0;

	// ****
	// Harness
	// ****
	always #2.5 mclk = ~mclk;
	// Wake pulses are counted as they come.
	always @(posedge mclk) if (wake === 1'b1) n_wake <= n_wake + 1;
	icwtb_ctrl dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp),
		.cmp_p_match(cmp_p), .cmp_a_match(cmp_a), .low_speed_tick(ls_tick), .wake(wake));
	icwtb_partner u_cpu (.mclk(mclk), .cpu_rsp(cpu_rsp), .cpu_req(cpu_req),
		.cmp_p_match(cmp_p), .cmp_a_match(cmp_a), .low_speed_tick(ls_tick));

	// Prints the counts and the verdict, then stops.
	task summarize;
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Compares one value.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// One bus transfer, held until waitrequest is sampled low at a rising edge.
	task automatic bus(input logic w, input logic [4:0] ad, input logic [7:0] d,
			input logic [3:0] be, output logic [31:0] q);
		int n;
		@(posedge mclk);
		avs_address <= ad;
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= be;
		avs_read <= ~w;
		avs_write <= w;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0) begin
			n_mismatch++;
			summarize();
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] ad, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, ad, d, 4'h1, q);
	endtask
	task automatic rc(input logic [4:0] ad, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, ad, 8'h00, 4'h1, q);
		chk(q, {24'h000000, e});
	endtask
	// Counts cycles until a load or an entry pulse; a required one that never comes ends the run.
	task automatic wsig(input logic pl, input int lim, input logic must, output int n);
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while ((pl ? cpu_rsp.pc_load : cpu_rsp.irq_taken) !== 1'b1 && n < lim);
		if (must && n >= lim) begin
			n_mismatch++;
			summarize();
		end
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_regs;
		logic [4:0]  ad [6] = '{PRIMARY_OFF, SHARED_OFF, CMP_OFF, PSC_OFF, TICK_OFF, 5'h18};
		logic [7:0]  wd [6] = '{8'hfa, 8'hee, 8'hcc, 8'hfe, 8'h7f, 8'hff};
		logic [7:0]  ex [6] = '{8'h20, 8'h00, 8'h00, 8'h02, 8'h07, 8'h00};
		logic [31:0] q;
		rc(STATUS_OFF, 8'h00);
		for (int i = 0; i < 6; i++)
			rc(ad[i], 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(ad[i], wd[i]);
			rc(ad[i], ex[i]);
		end
		bus(1'b1, PSC_OFF, 8'h01, 4'h0, q);
		rc(PSC_OFF, 8'h02);
		wr(PRIMARY_OFF, 8'h00);
		wr(TICK_OFF, 8'h00);
		$display("test regs done");
	endtask
	task automatic t_tick;
		logic [1:0] src [4] = '{SRC_SYS, SRC_SYS, SRC_SYS_DIV4, 2'h2};
		logic [2:0] sel [4] = '{3'h0, 3'h7, 3'h0, 3'h0};
		int         per [4] = '{256, 32768, 1024, 2048};
		int         n;
		wr(PRIMARY_OFF, 8'h05);
		for (int i = 0; i < 4; i++) begin
			wr(PSC_OFF, {6'h00, src[i]});
			wr(TICK_OFF, {5'h10, sel[i]});
			wsig(1'b0, 40000, 1'b1, n);
			chk(cpu_rsp.pc_addr, TICK_VEC);
			wsig(1'b0, 40000, 1'b1, n);
			chk(n, per[i]);
			wr(TICK_OFF, 8'h00);
		end
		wsig(1'b1, 20, 1'b1, n);
		rc(PRIMARY_OFF, 8'h05);
		wr(PRIMARY_OFF, 8'h00);
		$display("test tick done");
	endtask
	task automatic t_shared;
		int              n;
		int              nw;
		logic [PC_W-1:0] sv;
		u_cpu.auto_ret <= 1'b0;
		nw = n_wake;
		u_cpu.send(5'h02);
		u_cpu.send(5'h01);
		repeat (3) @(posedge mclk);
		chk(n_wake > nw, 1'b1);
		nw = n_wake;
		u_cpu.send(5'h02);
		repeat (4) @(posedge mclk);
		chk(n_wake, nw);
		rc(CMP_OFF, 8'h30);
		rc(SHARED_OFF, 8'h10);
		wr(PRIMARY_OFF, 8'h24);
		wr(SHARED_OFF, 8'h11);
		wr(CMP_OFF, 8'h33);
		wsig(1'b0, 40, 1'b0, n);
		chk(n, 40);
		wr(PRIMARY_OFF, 8'h25);
		wsig(1'b0, 20, 1'b1, n);
		chk(cpu_rsp.pc_addr, SHARED_VEC);
		rc(SHARED_OFF, 8'h01);
		rc(CMP_OFF, 8'h33);
		rc(PRIMARY_OFF, 8'h24);
		sv = u_cpu.saved;
		u_cpu.send(5'h04);
		wsig(1'b1, 20, 1'b1, n);
		chk(cpu_rsp.pc_addr, sv);
		wsig(1'b0, 20, 1'b1, n);
		chk(cpu_rsp.pc_addr, TICK_VEC);
		u_cpu.send(5'h04);
		wr(CMP_OFF, 8'h00);
		wr(PRIMARY_OFF, 8'h00);
		$display("test shared done");
	endtask
	task automatic t_gate;
		int n;
		wr(SHARED_OFF, 8'h01);
		wr(PRIMARY_OFF, 8'h01);
		u_cpu.send(5'h01);
		wsig(1'b0, 40, 1'b0, n);
		chk(n, 40);
		rc(CMP_OFF, 8'h20);
		for (int i = 0; i < STACK_DEPTH; i++)
			u_cpu.send(5'h10);
		wr(CMP_OFF, 8'h22);
		chk(cpu_rsp.stack_full, 1'b1);
		wsig(1'b0, 40, 1'b0, n);
		chk(n, 40);
		u_cpu.send(5'h08);
		wsig(1'b0, 20, 1'b1, n);
		chk(cpu_rsp.pc_addr, SHARED_VEC);
		wr(PRIMARY_OFF, 8'h25);
		wsig(1'b0, 20, 1'b0, n);
		chk(n, 20);
		u_cpu.bnd <= 1'b0;
		u_cpu.send(5'h08);
		wsig(1'b0, 20, 1'b0, n);
		chk(n, 20);
		u_cpu.bnd <= 1'b1;
		wsig(1'b0, 20, 1'b1, n);
		chk(cpu_rsp.pc_addr, TICK_VEC);
		u_cpu.send(5'h08);
		rc(PRIMARY_OFF, 8'h04);
		$display("test gate done");
	endtask

	// Reset, then every scenario in turn.
	initial begin
		avs_address <= 5'h00;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= 32'h0000_0000;
		avs_byteenable <= 4'h1;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		t_regs();
		t_tick();
		t_shared();
		t_gate();
		summarize();
	end
endmodule
